/* verilog/dmc_channel.sv */
// one dma channel: control registers, transfer sequencer, block handling
module dmc_channel
  import dmc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dma_request,
  input wire logic [15:0] per_index,
  output logic [15:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic ram_byte,
  output logic [15:0] ram_wdata,
  input wire logic [15:0] ram_rdata,
  output logic [15:0] per_addr,
  output logic per_rd,
  output logic per_wr,
  output logic per_byte,
  output logic [15:0] per_wdata,
  input wire logic [15:0] per_rdata,
  output logic irq
);
  // ==========================================================
  // declarations
  logic rd_take;
  logic wr_fire;
  logic [15:0] control_r;
  logic [15:0] control_nxt;
  logic [15:0] start_a_r;
  logic [15:0] start_a_nxt;
  logic [15:0] start_b_r;
  logic [15:0] start_b_nxt;
  logic [15:0] per_addr_r;
  logic [15:0] per_addr_nxt;
  logic [9:0] count_r;
  logic [9:0] count_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  dmc_state_t state_r;
  dmc_state_t state_nxt;
  logic [15:0] cur_addr_r;
  logic [15:0] cur_addr_nxt;
  logic [9:0] done_r;
  logic [9:0] done_nxt;
  logic buf_sel_r;
  logic buf_sel_nxt;
  logic [15:0] data_r;
  logic [15:0] data_nxt;
  logic [DMC_EVT_W-1:0] events;
  logic [DMC_EVT_W-1:0] irq_status;
  logic [DMC_EVT_W-1:0] irq_enable;
  logic ch_on;
  logic size_byte;
  logic dir_ram_src;
  logic half_sel;
  logic null_wr;
  logic [1:0] addr_sel;
  logic [1:0] op_mode;
  logic ctrl_we;
  logic [10:0] block_len;
  logic [10:0] half_point;
  logic [10:0] moved;
  logic block_end;
  logic [15:0] step;
  logic [15:0] ram_target;
  logic [15:0] src_data;

  // ==========================================================
  // avalon handshake and interrupt collector
  dmc_bus u_bus (
    .clock(clock),
    .reset(reset),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest),
    .rd_take(rd_take),
    .wr_fire(wr_fire)
  );

  dmc_irq u_irq (
    .clock(clock),
    .reset(reset),
    .event_set(events),
    .clear_we(wr_fire && avs_address == DMC_OFS_IRQ_CLEAR),
    .enable_we(wr_fire && avs_address == DMC_OFS_IRQ_ENABLE),
    .wdata(avs_writedata[DMC_EVT_W-1:0]),
    .status(irq_status),
    .enable(irq_enable),
    .irq(irq)
  );

  // ==========================================================
  // control field decode
  assign ch_on = control_r[DMC_BIT_ON];
  assign size_byte = control_r[DMC_BIT_SIZE];
  assign dir_ram_src = control_r[DMC_BIT_DIR];
  assign half_sel = control_r[DMC_BIT_HALF];
  assign null_wr = control_r[DMC_BIT_DUMMY_PERIPHERAL_WRITE];
  assign addr_sel = control_r[DMC_POS_ADDR_SEL +: 2];
  assign op_mode = control_r[DMC_POS_MODE +: 2];
  assign ctrl_we = wr_fire && avs_address == DMC_OFS_CONTROL;

  // block length is count plus one; halfway rounds down, at least one
  assign block_len = {1'b0, count_r} + 11'h001;
  assign half_point = (block_len[10:1] == 10'h000) ? 11'h001 : {1'b0, block_len[10:1]};
  assign moved = {1'b0, done_r} + 11'h001;
  assign block_end = moved == block_len;
  assign step = size_byte ? DMC_STEP_BYTE : DMC_STEP_WORD;

  // peripheral indirect forms the ram address from the peripheral offset
  assign ram_target = (addr_sel == DMC_AM_PER_IND) ?
                      ((buf_sel_r ? start_b_r : start_a_r) + per_index) :
                      cur_addr_r;

  // byte transfers carry the low byte only
  always_comb begin
    src_data = dir_ram_src ? ram_rdata : per_rdata;
    if (size_byte) begin
      src_data = {8'h00, src_data[7:0]};
    end
  end

  // ==========================================================
  // software registers; hardware clears channel_on after one-shot
  always_comb begin
    control_nxt = control_r;
    start_a_nxt = start_a_r;
    start_b_nxt = start_b_r;
    per_addr_nxt = per_addr_r;
    count_nxt = count_r;
    if (ctrl_we) begin
      control_nxt = avs_writedata[15:0] & DMC_CONTROL_MASK;
    end else if (state_r == DMC_ST_WRITE && block_end && op_mode[DMC_MODE_ONE_SHOT]) begin
      control_nxt[DMC_BIT_ON] = 1'b0;
    end
    if (wr_fire && avs_address == DMC_OFS_START_A) begin
      start_a_nxt = avs_writedata[15:0];
    end
    if (wr_fire && avs_address == DMC_OFS_START_B) begin
      start_b_nxt = avs_writedata[15:0];
    end
    if (wr_fire && avs_address == DMC_OFS_PER_ADDR) begin
      per_addr_nxt = avs_writedata[15:0];
    end
    if (wr_fire && avs_address == DMC_OFS_COUNT) begin
      count_nxt = avs_writedata[DMC_COUNT_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      control_r <= DMC_CONTROL_RESET;
      start_a_r <= DMC_START_RESET;
      start_b_r <= DMC_START_RESET;
      per_addr_r <= DMC_START_RESET;
      count_r <= DMC_COUNT_RESET;
    end else begin
      control_r <= control_nxt;
      start_a_r <= start_a_nxt;
      start_b_r <= start_b_nxt;
      per_addr_r <= per_addr_nxt;
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // read mux, registered in the wait cycle; unmapped reads zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_take) begin
      case (avs_address)
        DMC_OFS_CONTROL: rdata_nxt = {16'h0000, control_r};
        DMC_OFS_START_A: rdata_nxt = {16'h0000, start_a_r};
        DMC_OFS_START_B: rdata_nxt = {16'h0000, start_b_r};
        DMC_OFS_PER_ADDR: rdata_nxt = {16'h0000, per_addr_r};
        DMC_OFS_COUNT: rdata_nxt = {22'h000000, count_r};
        DMC_OFS_STATE: rdata_nxt = {6'h00, done_r, 14'h0000, buf_sel_r,
                                    state_r != DMC_ST_IDLE};
        DMC_OFS_IRQ_STATUS: rdata_nxt = {30'h00000000, irq_status};
        DMC_OFS_IRQ_ENABLE: rdata_nxt = {30'h00000000, irq_enable};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;

  // ==========================================================
  // transfer sequencer: read source, latch, write destination
  always_comb begin
    state_nxt = state_r;
    cur_addr_nxt = cur_addr_r;
    done_nxt = done_r;
    buf_sel_nxt = buf_sel_r;
    data_nxt = data_r;
    events = '0;
    case (state_r)
      DMC_ST_IDLE: begin
        if (dma_request && ch_on) begin
          if (addr_sel == DMC_AM_RESERVED) begin
            events[DMC_EVT_BAD_MODE] = 1'b1;
          end else begin
            state_nxt = DMC_ST_READ;
          end
        end
      end
      DMC_ST_READ: begin
        state_nxt = DMC_ST_LATCH;
      end
      DMC_ST_LATCH: begin
        data_nxt = src_data;
        state_nxt = DMC_ST_WRITE;
      end
      DMC_ST_WRITE: begin
        state_nxt = DMC_ST_IDLE;
        done_nxt = moved[9:0];
        if (addr_sel == DMC_AM_POST_INC) begin
          cur_addr_nxt = cur_addr_r + step;
        end
        // halfway event only when early interrupt is chosen
        if (half_sel && moved == half_point) begin
          events[DMC_EVT_BLOCK] = 1'b1;
        end
        if (block_end) begin
          if (!half_sel) begin
            events[DMC_EVT_BLOCK] = 1'b1;
          end
          done_nxt = 10'h000;
          if (op_mode[DMC_MODE_PING_PONG]) begin
            buf_sel_nxt = ~buf_sel_r;
            cur_addr_nxt = buf_sel_r ? start_a_r : start_b_r;
          end else begin
            cur_addr_nxt = buf_sel_r ? start_b_r : start_a_r;
          end
        end
      end
      default: begin
        state_nxt = DMC_ST_IDLE;
      end
    endcase
    // turning the channel on restarts from the primary buffer
    if (ctrl_we && avs_writedata[DMC_BIT_ON] && !ch_on) begin
      cur_addr_nxt = start_a_r;
      done_nxt = 10'h000;
      buf_sel_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= DMC_ST_IDLE;
      cur_addr_r <= DMC_START_RESET;
      done_r <= DMC_COUNT_RESET;
      buf_sel_r <= 1'b0;
      data_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cur_addr_r <= cur_addr_nxt;
      done_r <= done_nxt;
      buf_sel_r <= buf_sel_nxt;
      data_r <= data_nxt;
    end
  end

  // ==========================================================
  // bus strobes; data and the peripheral address come from registers, the ram address adds per_index in peripheral indirect mode
  assign ram_addr = ram_target;
  assign per_addr = per_addr_r;
  assign ram_byte = size_byte;
  assign per_byte = size_byte;
  assign ram_rd = state_r == DMC_ST_READ && dir_ram_src;
  assign per_rd = state_r == DMC_ST_READ && !dir_ram_src;
  assign ram_wr = state_r == DMC_ST_WRITE && !dir_ram_src;
  // peripheral written as destination, or with null data beside a ram write
  assign per_wr = state_r == DMC_ST_WRITE && (dir_ram_src || null_wr);
  assign ram_wdata = data_r;
  assign per_wdata = dir_ram_src ? data_r : 16'h0000;
endmodule

/* verilog/dmc_pkg.sv */
// constants shared by the dma channel control block
package dmc_pkg;
  // ==========================================================
  // register byte offsets on the avalon slave
  localparam logic [5:0] DMC_OFS_CONTROL = 6'h00;
  localparam logic [5:0] DMC_OFS_START_A = 6'h04;
  localparam logic [5:0] DMC_OFS_START_B = 6'h08;
  localparam logic [5:0] DMC_OFS_PER_ADDR = 6'h0c;
  localparam logic [5:0] DMC_OFS_COUNT = 6'h10;
  localparam logic [5:0] DMC_OFS_STATE = 6'h14;
  localparam logic [5:0] DMC_OFS_IRQ_STATUS = 6'h18;
  localparam logic [5:0] DMC_OFS_IRQ_CLEAR = 6'h1c;
  localparam logic [5:0] DMC_OFS_IRQ_ENABLE = 6'h20;

  // ==========================================================
  // channel control field positions
  localparam int DMC_BIT_ON = 15;
  localparam int DMC_BIT_SIZE = 14;
  localparam int DMC_BIT_DIR = 13;
  localparam int DMC_BIT_HALF = 12;
  localparam int DMC_BIT_DUMMY_PERIPHERAL_WRITE = 11;
  localparam int DMC_POS_ADDR_SEL = 4;
  localparam int DMC_POS_MODE = 0;
  localparam logic [15:0] DMC_CONTROL_MASK = 16'hf833;
  localparam logic [15:0] DMC_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] DMC_START_RESET = 16'h0000;
  localparam logic [9:0] DMC_COUNT_RESET = 10'h000;
  localparam int DMC_COUNT_W = 10;

  // addressing select codes
  localparam logic [1:0] DMC_AM_POST_INC = 2'h0;
  localparam logic [1:0] DMC_AM_NO_INC = 2'h1;
  localparam logic [1:0] DMC_AM_PER_IND = 2'h2;
  localparam logic [1:0] DMC_AM_RESERVED = 2'h3;

  // operating mode bit meanings
  localparam int DMC_MODE_ONE_SHOT = 0;
  localparam int DMC_MODE_PING_PONG = 1;

  // ==========================================================
  // interrupt event bits
  localparam int DMC_EVT_W = 2;
  localparam int DMC_EVT_BLOCK = 0;
  localparam int DMC_EVT_BAD_MODE = 1;

  // address steps
  localparam logic [15:0] DMC_STEP_BYTE = 16'h0001;
  localparam logic [15:0] DMC_STEP_WORD = 16'h0002;

  // transfer sequencer states
  typedef enum logic [3:0] {
    DMC_ST_IDLE = 4'h1,
    DMC_ST_READ = 4'h2,
    DMC_ST_LATCH = 4'h4,
    DMC_ST_WRITE = 4'h8
  } dmc_state_t;
endpackage

/* verilog/dmc_bus.sv */
// avalon-mm handshake: one wait cycle per access
module dmc_bus
  import dmc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  output logic avs_waitrequest,
  output logic rd_take,
  output logic wr_fire
);
  logic ack_r;
  logic ack_nxt;

  // ==========================================================
  // ack goes high for the second cycle of every access
  always_comb begin
    ack_nxt = (avs_read | avs_write) & ~ack_r;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign rd_take = avs_read & ~ack_r; // read data registered here
  assign wr_fire = avs_write & ack_r; // write commits here
endmodule

/* verilog/dmc_irq.sv */
// sticky interrupt status, enable and write-one-to-clear
module dmc_irq
  import dmc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [DMC_EVT_W-1:0] event_set,
  input wire logic clear_we,
  input wire logic enable_we,
  input wire logic [DMC_EVT_W-1:0] wdata,
  output logic [DMC_EVT_W-1:0] status,
  output logic [DMC_EVT_W-1:0] enable,
  output logic irq
);
  logic [DMC_EVT_W-1:0] status_r;
  logic [DMC_EVT_W-1:0] status_nxt;
  logic [DMC_EVT_W-1:0] enable_r;
  logic [DMC_EVT_W-1:0] enable_nxt;

  // ==========================================================
  // per bit: a new event wins over a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < DMC_EVT_W; g = g + 1) begin : g_bit
      always_comb begin
        status_nxt[g] = event_set[g] | (status_r[g] & ~(clear_we & wdata[g]));
        enable_nxt[g] = enable_we ? wdata[g] : enable_r[g];
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      status_r <= '0;
      enable_r <= '0;
    end else begin
      status_r <= status_nxt;
      enable_r <= enable_nxt;
    end
  end

  assign status = status_r;
  assign enable = enable_r;
  assign irq = |(status_r & enable_r); // level while any enabled bit set
endmodule

/* sim/dmc_channel_properties.sv */
// port-level assertion checker for the dma channel
module dmc_channel_properties
  import dmc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic dma_request,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic ram_byte,
  input wire logic [15:0] ram_wdata,
  input wire logic per_rd,
  input wire logic per_wr,
  input wire logic per_byte,
  input wire logic [15:0] per_wdata,
  input wire logic irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // register bus and control readback
  property p_bus_wait;
    $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait cycle wrong");
  property p_ctl_zero;
    avs_read && !avs_waitrequest && avs_address == DMC_OFS_CONTROL
      |-> avs_readdata[31:16] == 16'h0000 && avs_readdata[10:6] == 5'h00
        && avs_readdata[3:2] == 2'h0;
  endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("unused control bits set");
  // ==========================================================
  // transfer sequencing
  property p_take;
    (ram_rd || per_rd) |-> $past(dma_request);
  endproperty
  a_take: assert property (p_take) else $error("read without request");
  property p_strobe;
    ram_rd |=> !ram_rd [*3];
  endproperty
  a_strobe: assert property (p_strobe) else $error("ram read strobe too long");
  property p_dir_excl;
    !(ram_rd && per_rd);
  endproperty
  a_dir_excl: assert property (p_dir_excl) else $error("two sources read");
  property p_dir_r2p;
    ram_rd |-> ##2 per_wr && !ram_wr;
  endproperty
  a_dir_r2p: assert property (p_dir_r2p) else $error("ram source not to peripheral");
  property p_dir_p2r;
    per_rd |-> ##2 ram_wr;
  endproperty
  a_dir_p2r: assert property (p_dir_p2r) else $error("peripheral source not to ram");
  property p_null;
    ram_wr && per_wr |-> per_wdata == 16'h0000;
  endproperty
  a_null: assert property (p_null) else $error("dummy write carries data");
  property p_byte_ram;
    ram_wr && ram_byte |-> ram_wdata[15:8] == 8'h00;
  endproperty
  a_byte_ram: assert property (p_byte_ram) else $error("ram byte upper set");
  property p_byte_per;
    per_wr && per_byte && !ram_wr |-> per_wdata[15:8] == 8'h00;
  endproperty
  a_byte_per: assert property (p_byte_per) else $error("per byte upper set");
  // main scenarios
  c_null: cover property (ram_wr && per_wr);
  c_irq: cover property ($rose(irq));
  c_r2p: cover property (ram_rd ##2 per_wr);
endmodule

bind dmc_channel dmc_channel_properties chk (.clock, .reset, .avs_address, .avs_read,
  .avs_readdata, .avs_waitrequest, .dma_request, .ram_rd, .ram_wr, .ram_byte, .ram_wdata,
  .per_rd, .per_wr, .per_byte, .per_wdata, .irq);

/* sim/dmc_far_model.sv */
// behavioural dma ram and peripheral registers on the far side
module dmc_far_model
(
  input wire logic clock,
  input wire logic [15:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [15:0] ram_wdata,
  output logic [15:0] ram_rdata,
  input wire logic [15:0] per_addr,
  input wire logic per_rd,
  input wire logic per_wr,
  input wire logic [15:0] per_wdata,
  output logic [15:0] per_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ram_v_r = 1'b0, per_v_r = 1'b0;
  logic [15:0] ram_q_r = 16'h0000, per_q_r = 16'h0000;
  logic [15:0] ram_wa_r = 16'h0000, ram_wd_r = 16'h0000;
  logic [15:0] per_wa_r = 16'h0000, per_wd_r = 16'h0000;
  int n_ram_wr_r = 0, n_per_wr_r = 0;
  // answer reads the next cycle, record every write
  always @(posedge clock) begin
    ram_v_r <= ram_rd;
    per_v_r <= per_rd;
    if (ram_rd) ram_q_r <= 16'hc3c3 ^ ram_addr;
    if (per_rd) per_q_r <= 16'h5a5a ^ per_addr;
    if (ram_wr) begin
      ram_wa_r <= ram_addr;
      ram_wd_r <= ram_wdata;
      n_ram_wr_r <= n_ram_wr_r + 1;
    end
    if (per_wr) begin
      per_wa_r <= per_addr;
      per_wd_r <= per_wdata;
      n_per_wr_r <= n_per_wr_r + 1;
    end
  end
  // outside the answer cycle the data lines show garbage
  assign ram_rdata = ram_v_r ? ram_q_r : ~ram_q_r;
  assign per_rdata = per_v_r ? per_q_r : ~per_q_r;
endmodule

/* sim/tb.sv */
// self-checking bench for the dma channel control block
module tb
  import dmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset, avs_read, avs_write, avs_waitrequest, dma_request, irq;
  logic ram_rd, ram_wr, ram_byte, per_rd, per_wr, per_byte;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [15:0] per_index, ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  dmc_channel dut (.clock, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .dma_request, .per_index, .ram_addr, .ram_rd, .ram_wr,
    .ram_byte, .ram_wdata, .ram_rdata, .per_addr, .per_rd, .per_wr, .per_byte, .per_wdata,
    .per_rdata, .irq);
  dmc_far_model far (.clock, .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .ram_rdata,
    .per_addr, .per_rd, .per_wr, .per_wdata, .per_rdata);
  // ==========================================================
  // clock, timeout and verdict
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      $display("mismatch at %0t: timeout", $time);
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    chk(avs_readdata, exp);
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pulse;
    dma_request <= 1'b1;
    @(posedge clock);
    dma_request <= 1'b0;
    repeat (6) @(posedge clock);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd_chk(DMC_OFS_START_A, 32'h0000_0000);
    bus_wr(DMC_OFS_CONTROL, 32'hffff_ffff);
    rd_chk(DMC_OFS_CONTROL, 32'h0000_f833);
    rd_chk(6'h24, 32'h0000_0000);
    bus_wr(DMC_OFS_CONTROL, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_p2r;
    int n;
    bus_wr(DMC_OFS_START_A, 32'h0000_0004);
    bus_wr(DMC_OFS_PER_ADDR, 32'h0000_0020);
    bus_wr(DMC_OFS_COUNT, 32'h0000_0001);
    bus_wr(DMC_OFS_IRQ_ENABLE, 32'h0000_0003);
    rd_chk(DMC_OFS_IRQ_ENABLE, 32'h0000_0003);
    bus_wr(DMC_OFS_CONTROL, 32'h0000_8001);
    pulse();
    chk(far.ram_wa_r, 16'h0004);
    chk(far.ram_wd_r, 16'h5a7a);
    chk(irq, 1'b0);
    pulse();
    chk(far.ram_wa_r, 16'h0006);
    chk(irq, 1'b1);
    rd_chk(DMC_OFS_CONTROL, 32'h0000_0001);
    n = far.n_ram_wr_r;
    pulse();
    chk(far.n_ram_wr_r, n);
    bus_wr(DMC_OFS_IRQ_CLEAR, 32'h0000_0003);
    chk(irq, 1'b0);
    $display("test peripheral to ram done");
  endtask
  task automatic t_r2p;
    bus_wr(DMC_OFS_START_A, 32'h0000_0010);
    bus_wr(DMC_OFS_PER_ADDR, 32'h0000_0030);
    bus_wr(DMC_OFS_COUNT, 32'h0000_0003);
    bus_wr(DMC_OFS_CONTROL, 32'h0000_f010);
    chk(ram_byte, 1'b1);
    chk(per_byte, 1'b1);
    pulse();
    chk(far.per_wa_r, 16'h0030);
    chk(far.per_wd_r, 16'h00d3);
    chk(irq, 1'b0);
    pulse();
    chk(irq, 1'b1);
    bus_wr(DMC_OFS_IRQ_CLEAR, 32'h0000_0001);
    pulse();
    pulse();
    chk(irq, 1'b0);
    chk(far.per_wd_r, 16'h00d3);
    pulse();
    chk(far.n_per_wr_r, 5);
    rd_chk(DMC_OFS_STATE, 32'h0001_0000);
    rd_chk(DMC_OFS_CONTROL, 32'h0000_f010);
    $display("test ram to peripheral done");
  endtask
  task automatic t_ping;
    logic [15:0] exp [3] = '{16'h0000, 16'h0040, 16'h0000};
    bus_wr(DMC_OFS_CONTROL, 32'h0000_0000);
    bus_wr(DMC_OFS_START_A, 32'h0000_0000);
    bus_wr(DMC_OFS_START_B, 32'h0000_0040);
    bus_wr(DMC_OFS_COUNT, 32'h0000_0000);
    bus_wr(DMC_OFS_CONTROL, 32'h0000_8002);
    for (int i = 0; i < 3; i++) begin
      pulse();
      chk(far.ram_wa_r, exp[i]);
    end
    bus_wr(DMC_OFS_IRQ_CLEAR, 32'h0000_0003);
    rd_chk(DMC_OFS_STATE, 32'h0000_0002);
    $display("test ping-pong done");
  endtask
  task automatic t_null;
    int n;
    bus_wr(DMC_OFS_CONTROL, 32'h0000_0000);
    bus_wr(DMC_OFS_START_A, 32'h0000_0008);
    per_index <= 16'h0006;
    bus_wr(DMC_OFS_CONTROL, 32'h0000_c821);
    n = far.n_per_wr_r;
    pulse();
    chk(far.ram_wa_r, 16'h000e);
    chk(far.ram_wd_r, 16'h006a);
    chk(far.n_per_wr_r, n + 1);
    chk(far.per_wd_r, 16'h0000);
    bus_wr(DMC_OFS_IRQ_CLEAR, 32'h0000_0003);
    $display("test dummy write done");
  endtask
  task automatic t_resv;
    int n;
    bus_wr(DMC_OFS_CONTROL, 32'h0000_0000);
    bus_wr(DMC_OFS_CONTROL, 32'h0000_8031);
    n = far.n_ram_wr_r;
    pulse();
    rd_chk(DMC_OFS_IRQ_STATUS, 32'h0000_0002);
    chk(irq, 1'b1);
    chk(far.n_ram_wr_r, n);
    bus_wr(DMC_OFS_IRQ_CLEAR, 32'h0000_0002);
    rd_chk(DMC_OFS_IRQ_STATUS, 32'h0000_0000);
    $display("test reserved code done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0000_0000;
    dma_request = 1'b0;
    per_index = 16'h0000;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_regs();
    t_p2r();
    t_r2p();
    t_ping();
    t_null();
    t_resv();
    tally_and_finish();
  end
endmodule
